// ### rtl/iocf_pkg.sv
// Package for the interrupt routing and I/O base configuration block
package iocf_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 10;
    localparam int OFS_W = 4;
    localparam int NUM_LINES = 8;
    localparam logic [OFS_W-1:0] CFG_OFFSET = 4'h4;
    localparam logic [OFS_W-1:0] MODE_OFFSET = 4'h1;
    localparam logic [1:0] PAGE_CFG = 2'h3;
    localparam logic [1:0] MODE_CFG_WRITE = 2'h3;
    localparam int BIT_IRQ_EN = 7;
    localparam int SEL_HI = 6;
    localparam int SEL_LO = 4;
    localparam int BASE_HI = 3;
    localparam int BASE_LO = 0;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int BASE_FAR_BIT = 2;
    localparam int BASE_HIGH_BIT = 3;
    localparam logic [ADDR_W-1:0] BASE_300 = 10'h300;
    localparam logic [ADDR_W-1:0] BASE_200 = 10'h200;
    localparam logic [ADDR_W-1:0] BASE_STEP_HIGH = 10'h080;
    localparam logic [ADDR_W-1:0] BASE_STEP = 10'h020;
    localparam logic [ADDR_W-1:0] WINDOW_SIZE = 10'h020;
    localparam logic [DATA_W-1:0] CFG_POWERUP = 8'h80;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    typedef struct packed {
        logic irqEnable;
        logic [2:0] lineSelect;
        logic [3:0] ioBase;
    } iocf_cfg_s;

    typedef struct packed {
        logic [NUM_LINES-1:0] level;
        logic [NUM_LINES-1:0] drive;
    } iocf_irq_s;
endpackage

// ### rtl/iocf_line_drive.sv
// Routes the interrupt request onto the selected host line
module iocf_line_drive (
    input wire logic clock,
    input wire logic rst,
    input iocf_pkg::iocf_cfg_s cfg,
    input wire logic irqPending,
    output iocf_pkg::iocf_irq_s lines
);
    iocf_pkg::iocf_irq_s lines_r;
    iocf_pkg::iocf_irq_s lines_nxt;

    always_comb begin
        lines_nxt = '0;
        if (cfg.irqEnable) begin
            lines_nxt.drive[cfg.lineSelect] = 1'b1;
            lines_nxt.level[cfg.lineSelect] = irqPending;
        end
        // Disabled: every line released
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lines_r <= '0;
        end else begin
            lines_r <= lines_nxt;
        end
    end

    assign lines = lines_r;
endmodule // iocf_line_drive

// ### rtl/iocf_config.sv
// Interrupt routing and I/O base configuration register with host I/O decode
module iocf_config (
    input wire logic clock,
    input wire logic rst,
    input wire logic [iocf_pkg::ADDR_W-1:0] ioAddr,
    input wire logic ioRead,
    input wire logic ioWrite,
    input wire logic [iocf_pkg::DATA_W-1:0] ioWrData,
    input wire logic [1:0] pageSelect,
    input wire logic [1:0] eepromModeField,
    input wire logic loadStrobe,
    input wire logic [iocf_pkg::DATA_W-1:0] loadValue,
    input wire logic irqPending,
    output logic [iocf_pkg::DATA_W-1:0] ioRdData,
    output logic ioRdValid,
    output logic ioClaim,
    output logic [iocf_pkg::NUM_LINES-1:0] irqLineOut,
    output logic [iocf_pkg::NUM_LINES-1:0] irqLineOe,
    output logic [iocf_pkg::ADDR_W-1:0] ioBaseAddr
);
    // Host pins pass two flops before any decode reads them
    logic [iocf_pkg::ADDR_W-1:0] addrMeta_r;
    logic [iocf_pkg::ADDR_W-1:0] addrSync_r;
    logic [iocf_pkg::DATA_W-1:0] dataMeta_r;
    logic [iocf_pkg::DATA_W-1:0] dataSync_r;
    logic rdMeta_r;
    logic rdSync_r;
    logic wrMeta_r;
    logic wrSync_r;
    logic irqMeta_r;
    logic irqSync_r;
    logic [iocf_pkg::ADDR_W-1:0] addrMeta_nxt;
    logic [iocf_pkg::ADDR_W-1:0] addrSync_nxt;
    logic [iocf_pkg::DATA_W-1:0] dataMeta_nxt;
    logic [iocf_pkg::DATA_W-1:0] dataSync_nxt;
    logic rdMeta_nxt;
    logic rdSync_nxt;
    logic wrMeta_nxt;
    logic wrSync_nxt;
    logic irqMeta_nxt;
    logic irqSync_nxt;

    always_comb begin
        addrMeta_nxt = ioAddr;
        addrSync_nxt = addrMeta_r;
        dataMeta_nxt = ioWrData;
        dataSync_nxt = dataMeta_r;
        rdMeta_nxt = ioRead;
        rdSync_nxt = rdMeta_r;
        wrMeta_nxt = ioWrite;
        wrSync_nxt = wrMeta_r;
        irqMeta_nxt = irqPending;
        irqSync_nxt = irqMeta_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addrMeta_r <= '0;
            addrSync_r <= '0;
            dataMeta_r <= '0;
            dataSync_r <= '0;
            rdMeta_r <= 1'b0;
            rdSync_r <= 1'b0;
            wrMeta_r <= 1'b0;
            wrSync_r <= 1'b0;
            irqMeta_r <= 1'b0;
            irqSync_r <= 1'b0;
        end else begin
            addrMeta_r <= addrMeta_nxt;
            addrSync_r <= addrSync_nxt;
            dataMeta_r <= dataMeta_nxt;
            dataSync_r <= dataSync_nxt;
            rdMeta_r <= rdMeta_nxt;
            rdSync_r <= rdSync_nxt;
            wrMeta_r <= wrMeta_nxt;
            wrSync_r <= wrSync_nxt;
            irqMeta_r <= irqMeta_nxt;
            irqSync_r <= irqSync_nxt;
        end
    end

    // One cycle high on the first sample of a strobe level
    function automatic logic risingEdge(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // Host window base for a select code
    function automatic logic [iocf_pkg::ADDR_W-1:0] baseOf(
        input logic [iocf_pkg::BASE_HI:iocf_pkg::BASE_LO] sel
    );
        logic [iocf_pkg::ADDR_W-1:0] b;
        b = sel[iocf_pkg::BASE_FAR_BIT] ? iocf_pkg::BASE_200 : iocf_pkg::BASE_300;
        if (sel[iocf_pkg::BASE_HIGH_BIT]) begin
            b = b + iocf_pkg::BASE_STEP_HIGH;
        end
        b = b + iocf_pkg::BASE_STEP * sel[iocf_pkg::BASE_FAR_BIT-1:iocf_pkg::BASE_LO];
        return b;
    endfunction

    // Strobes get one more stage and a history flop, so address and
    // data have settled a cycle before the edge is taken
    logic rdHold_r;
    logic rdLast_r;
    logic wrHold_r;
    logic wrLast_r;
    logic rdHold_nxt;
    logic rdLast_nxt;
    logic wrHold_nxt;
    logic wrLast_nxt;
    logic rdPulse;
    logic wrPulse;

    always_comb begin
        rdHold_nxt = rdSync_r;
        rdLast_nxt = rdHold_r;
        wrHold_nxt = wrSync_r;
        wrLast_nxt = wrHold_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdHold_r <= 1'b0;
            rdLast_r <= 1'b0;
            wrHold_r <= 1'b0;
            wrLast_r <= 1'b0;
        end else begin
            rdHold_r <= rdHold_nxt;
            rdLast_r <= rdLast_nxt;
            wrHold_r <= wrHold_nxt;
            wrLast_r <= wrLast_nxt;
        end
    end

    assign rdPulse = risingEdge(rdHold_r, rdLast_r);
    assign wrPulse = risingEdge(wrHold_r, wrLast_r);

    iocf_pkg::iocf_cfg_s cfg_r;
    iocf_pkg::iocf_cfg_s cfg_nxt;
    logic [iocf_pkg::DATA_W-1:0] rdData_r;
    logic [iocf_pkg::DATA_W-1:0] rdData_nxt;
    logic rdValid_r;
    logic rdValid_nxt;
    logic claim_r;
    logic claim_nxt;
    logic [iocf_pkg::ADDR_W-1:0] base_r;
    logic [iocf_pkg::ADDR_W-1:0] base_nxt;
    logic [iocf_pkg::ADDR_W-1:0] hostOffset;
    logic inWindow;
    logic atReg;
    logic cfgWriteOk;

    // Wraps below the base, landing far above the window; no carry out
    // of the top base, unlike a compare against base plus size
    assign hostOffset = addrSync_r - base_r;
    assign inWindow = hostOffset < iocf_pkg::WINDOW_SIZE;
    // Full offset compared, so no alias in the upper half of the window
    assign atReg = inWindow && (pageSelect == iocf_pkg::PAGE_CFG)
        && (hostOffset[iocf_pkg::ADDR_W-1:iocf_pkg::OFS_W] == '0)
        && (hostOffset[iocf_pkg::OFS_W-1:0] == iocf_pkg::CFG_OFFSET);
    assign cfgWriteOk = wrPulse && atReg && (eepromModeField == iocf_pkg::MODE_CFG_WRITE);

    always_comb begin
        cfg_nxt = cfg_r;
        if (loadStrobe) begin
            // Load beats a host write landing in the same cycle
            cfg_nxt = loadValue;
        end else if (cfgWriteOk) begin
            // Only the enable bit takes host data; read-only bits untouched
            cfg_nxt.irqEnable = dataSync_r[iocf_pkg::BIT_IRQ_EN];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= iocf_pkg::CFG_POWERUP;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    always_comb begin
        rdData_nxt = rdData_r;
        rdValid_nxt = 1'b0;
        if (rdPulse && atReg) begin
            rdData_nxt = cfg_r;
            rdValid_nxt = 1'b1;
        end else if (rdPulse && inWindow) begin
            // Other offsets belong to neighbouring registers
            rdData_nxt = iocf_pkg::ZERO_BYTE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData_r <= iocf_pkg::ZERO_BYTE;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    always_comb begin
        claim_nxt = inWindow && (rdHold_r || wrHold_r);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            claim_r <= 1'b0;
        end else begin
            claim_r <= claim_nxt;
        end
    end

    always_comb begin
        base_nxt = baseOf(cfg_nxt.ioBase);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_r <= iocf_pkg::BASE_300;
        end else begin
            base_r <= base_nxt;
        end
    end

    iocf_pkg::iocf_irq_s lines;

    iocf_line_drive iocf_line_drive_inst (
        .clock(clock),
        .rst(rst),
        .cfg(cfg_r),
        .irqPending(irqSync_r),
        .lines(lines)
    );

    assign ioRdData = rdData_r;
    assign ioRdValid = rdValid_r;
    assign ioClaim = claim_r;
    assign irqLineOut = lines.level;
    assign irqLineOe = lines.drive;
    assign ioBaseAddr = base_r;
endmodule // iocf_config

// ### sim/iocf_properties.sv
// Port checker for the configuration register block
module iocf_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic ioRead,
    input wire logic ioWrite,
    input wire logic irqPending,
    input wire logic ioRdValid,
    input wire logic ioClaim,
    input wire logic [7:0] ioRdData,
    input wire logic [7:0] irqLineOut,
    input wire logic [7:0] irqLineOe,
    input wire logic [9:0] ioBaseAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    one_line_a: assert property ($onehot0(irqLineOe)) else $error("two lines driven");
    out_masked_a: assert property ((irqLineOut & ~irqLineOe) == 8'h00) else $error("level on released line");
    en_drive_a: assert property (ioRdValid |-> (ioRdData[7] == (|irqLineOe))) else $error("enable mismatch");
    valid_pulse_a: assert property (ioRdValid |=> !ioRdValid) else $error("read valid too long");
    claim_valid_a: assert property (ioRdValid |-> ioClaim) else $error("unclaimed read");
    claim_cause_a: assert property ($rose(ioClaim) |-> $past(ioRead || ioWrite, 3)) else $error("claim w/o strobe");
    base_map_a: assert property (ioRdValid |-> ioBaseAddr == ((ioRdData[2] ? 10'h200 : 10'h300)
        + {ioRdData[3], 7'h00} + {ioRdData[1:0], 5'h00})) else $error("base decode wrong");
    irq_follow_a: assert property (|irqLineOe |-> (|(irqLineOut & irqLineOe)) == $past(irqPending, 3))
        else $error("line level wrong");
endmodule // iocf_properties
bind iocf_config iocf_properties iocf_properties_inst (
    .clock(clock),
    .rst(rst),
    .ioRead(ioRead),
    .ioWrite(ioWrite),
    .irqPending(irqPending),
    .ioRdValid(ioRdValid),
    .ioClaim(ioClaim),
    .ioRdData(ioRdData),
    .irqLineOut(irqLineOut),
    .irqLineOe(irqLineOe),
    .ioBaseAddr(ioBaseAddr)
);

// ### sim/iocf_irq_host.sv
// Host side interrupt lines, released lines float
module iocf_irq_host (
    input wire logic [7:0] lineOut,
    input wire logic [7:0] lineOe,
    output wire [7:0] irqWire
);
    timeunit 1ns;
    timeprecision 1ps;
    for (genvar i = 0; i < 8; i++) begin : g_line
        assign irqWire[i] = lineOe[i] ? lineOut[i] : 1'bz;
    end
endmodule // iocf_irq_host

// ### sim/tb_top.sv
// Self-checking bench for the configuration register block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, ioRead = 0, ioWrite = 0, loadStrobe = 0, irqPending = 0, ioRdValid, ioClaim, v, c;
    logic [1:0] pageSelect = 2'h3, eepromModeField = 2'h0;
    logic [7:0] ioWrData = 8'h00, loadValue = 8'h00, ioRdData, irqLineOut, irqLineOe, q;
    logic [9:0] ioAddr = 10'h000, ioBaseAddr;
    wire [7:0] irqWire;
    int num_errors = 0, n_tests = 0, cyc = 0;
    iocf_config iocf_config_inst (
        .clock(clock),
        .rst(rst),
        .ioAddr(ioAddr),
        .ioRead(ioRead),
        .ioWrite(ioWrite),
        .ioWrData(ioWrData),
        .pageSelect(pageSelect),
        .eepromModeField(eepromModeField),
        .loadStrobe(loadStrobe),
        .loadValue(loadValue),
        .irqPending(irqPending),
        .ioRdData(ioRdData),
        .ioRdValid(ioRdValid),
        .ioClaim(ioClaim),
        .irqLineOut(irqLineOut),
        .irqLineOe(irqLineOe),
        .ioBaseAddr(ioBaseAddr)
    );
    iocf_irq_host iocf_irq_host_inst (.lineOut(irqLineOut), .lineOe(irqLineOe), .irqWire(irqWire));
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // Strobe held six cycles, then low four so the edge detect rearms
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        ioAddr = a;
        ioWrData = d;
        ioRead = !w;
        ioWrite = w;
        v = 0;
        c = 0;
        repeat (6) begin
            @(posedge clock);
            #1 v = v | ioRdValid;
            c = c | ioClaim;
        end
        q = ioRdData;
        ioRead = 0;
        ioWrite = 0;
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic t_reset;
        irqPending = 1;
        acc(0, 10'h304, 8'h00);
        chk("pwrup", {v, q}, 9'h180);
        chk("base", ioBaseAddr, 10'h300);
        chk("line0", irqWire, 8'bzzzzzzz1);
        irqPending = 0;
        repeat (4) @(posedge clock);
        #1 chk("line0 low", irqWire, 8'bzzzzzzz0);
        irqPending = 1;
        $display("reset test done");
    endtask
    task automatic t_write;
        acc(1, 10'h304, 8'h00);
        acc(0, 10'h304, 8'h00);
        chk("locked", q, 8'h80);
        eepromModeField = 2'h3;
        acc(1, 10'h304, 8'h00);
        acc(0, 10'h304, 8'h00);
        chk("cleared", q, 8'h00);
        chk("off", irqWire, 8'hzz);
        acc(1, 10'h304, 8'hFF);
        acc(0, 10'h304, 8'h00);
        chk("ro bits", q, 8'h80);
        $display("write test done");
    endtask
    task automatic ld(input logic [7:0] d);
        loadValue = d;
        loadStrobe = 1;
        @(posedge clock);
        #1 loadStrobe = 0;
        repeat (5) @(posedge clock);
        #1;
    endtask
    task automatic t_load;
        ld(8'hD5);
        chk("base 220", ioBaseAddr, 10'h220);
        chk("line5", irqWire, 8'bzz1zzzzz);
        acc(0, 10'h224, 8'h00);
        chk("new win", {c, v, q}, 10'h3D5);
        acc(0, 10'h234, 8'h00);
        chk("no alias", {c, v}, 2'h2);
        acc(0, 10'h304, 8'h00);
        chk("old win", {c, v}, 2'h0);
        ld(8'h8B);
        chk("base 3E0", ioBaseAddr, 10'h3E0);
        acc(0, 10'h3E4, 8'h00);
        chk("top win", {c, v, q}, 10'h38B);
        pageSelect = 2'h0;
        acc(0, 10'h3E4, 8'h00);
        chk("page0", {c, v}, 2'h2);
        $display("load test done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        #1 rst = 0;
        t_reset();
        t_write();
        t_load();
        end_sim();
    end
endmodule // tb_top
